// >>> dcss_pkg.sv
package dcss_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned HOLD_MS = 36;
    localparam int unsigned HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
    localparam int unsigned PROBE_TIMEOUT = 4096;
    localparam int unsigned BLK_WVGA = 8;
    localparam int unsigned BLK_720P = 12;
    localparam int unsigned BLK_1080P = 16;
    // Array size codes
    localparam logic [1:0] ARR_WVGA = 2'h0;
    localparam logic [1:0] ARR_QHD = 2'h1;
    localparam logic [1:0] ARR_720P = 2'h2;
    localparam logic [1:0] ARR_1080P = 2'h3;
    // Interrupt status bit positions
    localparam int unsigned EV_BOOTED = 0;
    localparam int unsigned EV_ID_FAIL = 1;
    localparam int unsigned EV_ABORT = 2;
    localparam int unsigned EV_PARK = 3;
    localparam int unsigned EV_W = 4;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    // Identity checks
    typedef struct packed {
        logic ctrl_ok;
        logic array_ok;
        logic pmic_ok;
    } dcss_ids_t;
    typedef struct packed {
        logic core_en;
        logic rest_en;
        logic hold_en;
    } dcss_supply_t;
endpackage

// >>> dcss_sync.sv
`timescale 1ns/1ps
module dcss_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] m_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            m_q <= '0;
            q <= '0;
        end
        else
        begin
            m_q <= d;
            q <= m_q;
        end
    end
endmodule

// >>> dcss_blkseq.sv
`timescale 1ns/1ps
module dcss_blkseq (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] arr_size,
    input wire logic run,
    input wire logic step,
    output logic [15:0] blk_onehot
);
    function automatic logic [4:0] blk_count(input logic [1:0] s);
        unique case (s)
            dcss_pkg::ARR_720P: blk_count = 5'(dcss_pkg::BLK_720P);
            dcss_pkg::ARR_1080P: blk_count = 5'(dcss_pkg::BLK_1080P);
            default: blk_count = 5'(dcss_pkg::BLK_WVGA);
        endcase
    endfunction
    logic [3:0] idx_q;
    always_ff @(posedge clk)
    begin
        if (rst || !run)
            idx_q <= 4'h0;
        else if (step)
        begin
            // Wrap at the block count for the array size
            if (5'(idx_q) + 5'h1 >= blk_count(arr_size))
                idx_q <= 4'h0;
            else
                idx_q <= idx_q + 4'h1;
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst || !run)
            blk_onehot <= 16'h0000;
        else
            blk_onehot <= 16'h0001 << idx_q; // single block only
    end
endmodule

// >>> dcss_top.sv
`timescale 1ns/1ps
module dcss_top #(
    parameter int unsigned HOLD_CYCLES = dcss_pkg::HOLD_CYC,
    parameter int unsigned PROBE_CYCLES = dcss_pkg::PROBE_TIMEOUT
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Power chip pins
    input wire logic SYSTEM_POWER_GOOD,
    input wire logic PROJECTOR_POWER_REQUEST,
    input wire logic MIRROR_PARK_N,
    // Lane straps
    input wire logic [1:0] LANE_STRAP,
    // Array ID probe
    output logic ID_PROBE_START,
    input wire logic ID_PROBE_DONE,
    input wire logic ID_PROBE_OK,
    input wire logic [1:0] ARRAY_SIZE,
    // Identity checks from firmware
    input wire dcss_pkg::dcss_ids_t ID_CHECK,
    // Supplies and array pins
    output dcss_pkg::dcss_supply_t SUPPLY_EN,
    output logic ARRAY_RESET_N,
    output logic [15:0] RESET_BLOCK_SEL,
    input wire logic RESET_BLOCK_STEP,
    // Status
    output logic [2:0] LANE_COUNT_M1,
    output logic ARRAY_CONNECTED,
    output logic BOOT_ABORTED,
    output logic HOST_IRQ_N,
    output logic IRQ,
    // Register port
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA
);
    localparam logic [1:0] A_STATUS = 2'h0;
    localparam logic [1:0] A_MASK = 2'h1;
    localparam logic [1:0] A_STATE = 2'h2;

    typedef enum logic [6:0] {
        S_OFF = 7'h01,
        S_CORE = 7'h02,
        S_PROBE = 7'h04,
        S_CHECK = 7'h08,
        S_RUN = 7'h10,
        S_HOLD = 7'h20,
        S_ABORT = 7'h40
    } dcss_state_t;

    logic pwr_s, req_s, park_n_s, probe_done_s, probe_ok_s;
    logic [1:0] strap_s;
    dcss_state_t st_q;
    logic [31:0] cnt_q;
    logic rst_dly_q;
    logic [1:0] lanes_q;
    logic conn_q;
    logic [dcss_pkg::EV_W-1:0] sts_q, mask_q, ev;
    logic booted_q;

    dcss_sync #(.W(5)) u_sync (
        .clk(CLK),
        .rst(RST),
        .d({SYSTEM_POWER_GOOD, PROJECTOR_POWER_REQUEST, MIRROR_PARK_N,
            ID_PROBE_DONE, ID_PROBE_OK}),
        .q({pwr_s, req_s, park_n_s, probe_done_s, probe_ok_s})
    );
    dcss_sync #(.W(2)) u_strap (
        .clk(CLK),
        .rst(RST),
        .d(LANE_STRAP),
        .q(strap_s)
    );

    // Straps latched in the second cycle after synchroniser fills
    always_ff @(posedge CLK)
    begin
        if (RST)
            rst_dly_q <= 1'b0;
        else
            rst_dly_q <= 1'b1;
    end
    logic [1:0] rel_cnt_q;
    always_ff @(posedge CLK)
    begin
        if (RST)
            rel_cnt_q <= 2'h0;
        else if (rst_dly_q && rel_cnt_q != 2'h3)
            rel_cnt_q <= rel_cnt_q + 2'h1;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
            lanes_q <= 2'h0;
        else if (rel_cnt_q == 2'h2)
            lanes_q <= strap_s; // MSB is higher strap
    end
    assign LANE_COUNT_M1 = {1'b0, lanes_q};

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q <= S_OFF;
            cnt_q <= 32'h0;
            conn_q <= 1'b0;
            booted_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 32'h1;
            unique case (st_q)
                S_OFF:
                    if (pwr_s && req_s && rel_cnt_q == 2'h3)
                    begin
                        st_q <= S_CORE;
                        cnt_q <= 32'h0;
                    end
                S_CORE:
                    // Core and hold supplies only, then probe
                    begin
                        st_q <= S_PROBE;
                        cnt_q <= 32'h0;
                    end
                S_PROBE:
                    if (probe_done_s || cnt_q >= PROBE_CYCLES)
                    begin
                        // Failed probe still continues
                        conn_q <= probe_done_s && probe_ok_s;
                        st_q <= S_CHECK;
                    end
                S_CHECK:
                    if (ID_CHECK.ctrl_ok && ID_CHECK.array_ok &&
                        ID_CHECK.pmic_ok)
                    begin
                        st_q <= S_RUN;
                        booted_q <= 1'b1;
                    end
                    else
                        st_q <= S_ABORT;
                S_RUN:
                    if (!req_s || !pwr_s)
                    begin
                        st_q <= S_HOLD;
                        cnt_q <= 32'h0;
                        booted_q <= 1'b0;
                    end
                S_HOLD:
                    // Keep core supplies for shutdown window
                    if (cnt_q >= HOLD_CYCLES - 1)
                        st_q <= S_OFF;
                S_ABORT:
                    if (!req_s)
                        st_q <= S_OFF;
            endcase
        end
    end

    assign SUPPLY_EN.core_en = (st_q != S_OFF) && (st_q != S_ABORT);
    assign SUPPLY_EN.rest_en = (st_q == S_CHECK) || (st_q == S_RUN);
    assign SUPPLY_EN.hold_en = (st_q != S_OFF);
    assign ARRAY_RESET_N = (st_q == S_PROBE) || (st_q == S_CHECK) ||
        (st_q == S_RUN);
    assign ID_PROBE_START = (st_q == S_CORE);
    assign ARRAY_CONNECTED = conn_q;
    assign BOOT_ABORTED = (st_q == S_ABORT);
    assign HOST_IRQ_N = !booted_q; // low once booted

    dcss_blkseq u_blk (
        .clk(CLK),
        .rst(RST),
        .arr_size(ARRAY_SIZE),
        .run(st_q == S_RUN && conn_q),
        .step(RESET_BLOCK_STEP),
        .blk_onehot(RESET_BLOCK_SEL)
    );

    // Events; park low is an error
    always_comb
    begin
        ev = '0;
        ev[dcss_pkg::EV_BOOTED] = (st_q == S_CHECK) && ID_CHECK.ctrl_ok &&
            ID_CHECK.array_ok && ID_CHECK.pmic_ok;
        ev[dcss_pkg::EV_ID_FAIL] = (st_q == S_PROBE) &&
            (probe_done_s || cnt_q >= PROBE_CYCLES) &&
            !(probe_done_s && probe_ok_s);
        ev[dcss_pkg::EV_ABORT] = (st_q == S_CHECK) && !(ID_CHECK.ctrl_ok &&
            ID_CHECK.array_ok && ID_CHECK.pmic_ok);
        ev[dcss_pkg::EV_PARK] = (st_q == S_RUN) && !park_n_s;
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge CLK)
    begin
        if (RST)
            sts_q <= '0;
        else if (REG_WR && REG_ADDR == A_STATUS)
            sts_q <= (sts_q & ~REG_WDATA[dcss_pkg::EV_W-1:0]) | ev;
        else
            sts_q <= sts_q | ev;
    end
    always_ff @(posedge CLK)
    begin
        if (RST)
            mask_q <= dcss_pkg::MASK_RST;
        else if (REG_WR && REG_ADDR == A_MASK)
            mask_q <= REG_WDATA[dcss_pkg::EV_W-1:0];
    end
    assign IRQ = |(sts_q & mask_q);

    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            unique case (REG_ADDR)
                A_STATUS: REG_RDATA <= {4'h0, sts_q};
                A_MASK: REG_RDATA <= {4'h0, mask_q};
                A_STATE: REG_RDATA <= {st_q[6:4] != 3'h0, conn_q, lanes_q,
                    st_q[3:0]};
                default: REG_RDATA <= 8'h00;
            endcase
        end
        else
            REG_RDATA <= 8'h00;
    end
endmodule

// >>> dcss_checker.sv
`timescale 1ns/1ps
module dcss_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Watched pins
    input wire logic [1:0] LANE_STRAP,
    input wire logic PROJECTOR_POWER_REQUEST,
    input wire logic SYSTEM_POWER_GOOD,
    input wire logic ID_PROBE_START,
    input wire dcss_pkg::dcss_ids_t ID_CHECK,
    input wire dcss_pkg::dcss_supply_t SUPPLY_EN,
    input wire logic [1:0] ARRAY_SIZE,
    input wire logic [15:0] RESET_BLOCK_SEL,
    input wire logic [2:0] LANE_COUNT_M1,
    input wire logic ARRAY_CONNECTED,
    input wire logic BOOT_ABORTED,
    input wire logic HOST_IRQ_N
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic [3:0] cyc_q;
    // Saturating count of cycles since reset release
    always_ff @(posedge CLK)
    begin
        if (RST)
            cyc_q <= 4'h0;
        else if (cyc_q != 4'hf)
            cyc_q <= cyc_q + 4'h1;
    end
    chk_probe_core_only: assert property (
        ID_PROBE_START |-> SUPPLY_EN.core_en && !SUPPLY_EN.rest_en)
        else $error("probe with rest supply on");
    chk_conn_rest_on: assert property (
        ARRAY_CONNECTED && !HOST_IRQ_N |-> SUPPLY_EN.rest_en)
        else $error("connected array without supplies");
    chk_boot_ids_ok: assert property (
        $fell(HOST_IRQ_N) |-> $past(ID_CHECK) == 3'h7)
        else $error("boot despite id mismatch");
    chk_abort_no_boot: assert property (
        BOOT_ABORTED |-> HOST_IRQ_N)
        else $error("boot flag while aborted");
    chk_boot_needs_req: assert property (
        $fell(HOST_IRQ_N) |->
        $past(PROJECTOR_POWER_REQUEST) && $past(SYSTEM_POWER_GOOD))
        else $error("boot flag without power");
    chk_lane_capture: assert property (
        cyc_q == 4'h8 |-> LANE_COUNT_M1 == {1'b0, $past(LANE_STRAP, 7)})
        else $error("lane count wrong");
    chk_lane_held: assert property (
        cyc_q > 4'h8 |-> $stable(LANE_COUNT_M1))
        else $error("lane count changed");
    chk_one_block: assert property (
        $onehot0(RESET_BLOCK_SEL))
        else $error("several reset blocks");
    chk_block_range: assert property (
        ARRAY_SIZE == 2'h2 |-> RESET_BLOCK_SEL[15:12] == 4'h0)
        else $error("block beyond 12");
endmodule
bind dcss_top dcss_checker CHK (.CLK(CLK), .RST(RST),
    .LANE_STRAP(LANE_STRAP), .SYSTEM_POWER_GOOD(SYSTEM_POWER_GOOD),
    .PROJECTOR_POWER_REQUEST(PROJECTOR_POWER_REQUEST),
    .ID_PROBE_START(ID_PROBE_START), .ID_CHECK(ID_CHECK),
    .SUPPLY_EN(SUPPLY_EN), .ARRAY_SIZE(ARRAY_SIZE),
    .RESET_BLOCK_SEL(RESET_BLOCK_SEL), .LANE_COUNT_M1(LANE_COUNT_M1),
    .ARRAY_CONNECTED(ARRAY_CONNECTED), .BOOT_ABORTED(BOOT_ABORTED),
    .HOST_IRQ_N(HOST_IRQ_N));

// >>> dcss_far_model.sv
`timescale 1ns/1ps
module dcss_far_model #(
    parameter int DLY = 5
) (
    // Clock
    input wire logic clk,
    // Controls
    input wire logic req,
    input wire logic start,
    input wire logic ok_en,
    input wire logic err,
    // Pins toward the controller
    output logic done,
    output logic ok,
    output logic park_n
);
    logic [3:0] cnt_q;
    // Array answers only some cycles after a probe starts
    always_ff @(posedge clk)
    begin
        if (!req)
            cnt_q <= 4'h0;
        else if (start || (cnt_q != 4'h0 && !done))
            cnt_q <= cnt_q + 4'h1;
    end
    assign done = cnt_q == DLY[3:0];
    // Result line not valid before done
    assign ok = done ? ok_en : !ok_en;
    assign park_n = req && !err;
endmodule

// >>> dcss_top_tb.sv
`timescale 1ns/1ps
module dcss_top_tb;
    logic CLK, RST, pgood, req, park_n, start, done, ok, ok_en, err;
    logic step, conn, abort, irq_n, irq, wr, rd, arst_n;
    logic [1:0] strap, asize, addr;
    logic [7:0] wdata, rdata;
    logic [2:0] lanes;
    logic [15:0] blk;
    dcss_pkg::dcss_ids_t ids;
    dcss_pkg::dcss_supply_t sup;
    int n_mismatch, num_checks;
    dcss_top #(.HOLD_CYCLES(20), .PROBE_CYCLES(16)) DUT (.CLK(CLK),
        .RST(RST), .SYSTEM_POWER_GOOD(pgood),
        .PROJECTOR_POWER_REQUEST(req), .MIRROR_PARK_N(park_n),
        .LANE_STRAP(strap), .ID_PROBE_START(start), .ID_PROBE_DONE(done),
        .ID_PROBE_OK(ok), .ARRAY_SIZE(asize), .ID_CHECK(ids),
        .SUPPLY_EN(sup), .ARRAY_RESET_N(arst_n), .RESET_BLOCK_SEL(blk),
        .RESET_BLOCK_STEP(step), .LANE_COUNT_M1(lanes),
        .ARRAY_CONNECTED(conn), .BOOT_ABORTED(abort), .HOST_IRQ_N(irq_n),
        .IRQ(irq), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata));
    dcss_far_model FAR (.clk(CLK), .req(req), .start(start),
        .ok_en(ok_en), .err(err), .done(done), .ok(ok), .park_n(park_n));
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    task automatic chk(input logic [15:0] got, exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask
    task automatic wait_for(ref logic s, input logic v);
        for (int i = 0; i < 300 && s !== v; i++)
            @(posedge CLK);
        if (s !== v)
        begin
            chk(s, v, "timeout");
            finish_test();
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge CLK);
        wr <= 1'b0;
    endtask
    // Data is sampled in the one cycle where it stands
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge CLK);
        rd <= 1'b0;
        @(posedge CLK);
        chk(rdata, e, "read data");
    endtask
    task automatic do_reset(input logic [1:0] s, input logic okv,
        input logic [2:0] idv);
        RST <= 1'b1;
        strap <= s;
        req <= 1'b0;
        pgood <= 1'b0;
        err <= 1'b0;
        ok_en <= okv;
        ids <= idv;
        cyc(8);
        RST <= 1'b0;
        cyc(10);
        chk(lanes, {1'b0, s}, "lane count");
        pgood <= 1'b1;
        req <= 1'b1;
    endtask
    // Block select must return to the first block after nb steps
    task automatic step_blocks(input int nb);
        logic [15:0] first;
        first = blk;
        chk($onehot(first), 1'b1, "one block");
        for (int i = 0; i < nb; i++)
        begin
            step <= 1'b1;
            @(posedge CLK);
            step <= 1'b0;
            cyc(2);
            chk(blk === first, i == nb - 1, "block wrap");
        end
    endtask
    task automatic scen_boot_ok();
        int n;
        do_reset(2'h2, 1'b1, 3'h7);
        wait_for(irq_n, 1'b0);
        cyc(2);
        chk(conn, 1'b1, "connected");
        chk(sup.rest_en, 1'b1, "rest supply");
        chk(arst_n, 1'b1, "array reset released");
        strap <= 2'h1;
        cyc(8);
        chk(lanes, 3'h2, "lanes held");
        step_blocks(12);
        rd_reg(2'h0, 8'h01);
        rd_reg(2'h3, 8'h00);
        wr_reg(2'h1, 8'h01);
        cyc(2);
        chk(irq, 1'b1, "irq unmasked");
        wr_reg(2'h1, 8'h00);
        cyc(2);
        chk(irq, 1'b0, "mask");
        wr_reg(2'h0, 8'h01);
        rd_reg(2'h0, 8'h00);
        err <= 1'b1;
        cyc(8);
        rd_reg(2'h0, 8'h08);
        req <= 1'b0;
        n = 0;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge CLK);
            n += int'(sup.hold_en && !sup.rest_en);
        end
        chk(n >= 20, 1'b1, "hold time");
        chk(sup, 3'h0, "supplies off");
        chk(arst_n, 1'b0, "array reset held");
    endtask
    task automatic scen_blocks_1080p();
        asize <= 2'h3;
        do_reset(2'h1, 1'b1, 3'h7);
        wait_for(irq_n, 1'b0);
        cyc(2);
        step_blocks(16);
    endtask
    task automatic scen_probe_fail();
        do_reset(2'h0, 1'b0, 3'h7);
        wait_for(irq_n, 1'b0);
        chk(conn, 1'b0, "not connected");
        rd_reg(2'h0, 8'h03);
    endtask
    task automatic scen_id_bad();
        do_reset(2'h3, 1'b1, 3'h5);
        wait_for(abort, 1'b1);
        cyc(4);
        chk(irq_n, 1'b1, "no boot");
        rd_reg(2'h0, 8'h04);
    endtask
    initial
    begin
        {RST, pgood, req, err, ok_en, step, wr, rd} = 8'h80;
        {strap, addr, wdata, ids} = 15'h0;
        asize = 2'h2;
        scen_boot_ok();
        scen_probe_fail();
        scen_id_bad();
        scen_blocks_1080p();
        finish_test();
    end
endmodule
